// >>> src/safety_mode_defs.svh
`ifndef SAFETY_MODE_DEFS_SVH
`define SAFETY_MODE_DEFS_SVH

// Register byte offsets
`define ADDR_CMD      8'h00
`define ADDR_STAT     8'h04
`define ADDR_LED      8'h08
`define ADDR_EVT      8'h0C

// Command register fields
`define CMD_MODE_MSB  2
`define CMD_MODE_LSB  0
`define CMD_SESS_ON   4
`define CMD_SESS_OFF  5
`define CMD_FORCE     6
`define CMD_DOWNLOAD  8

// Mode request codes
`define REQ_PROG      3'h1
`define REQ_DSTOP     3'h2
`define REQ_DRUN      3'h3
`define REQ_RUN       3'h4

// Event register bits
`define EVT_FORCE_REJ 0
`define EVT_SESS_REJ  1
`define EVT_MODE_REJ  2
`define EVT_TIMEOUT   3

// Timing
`define CLK_HZ        100000000
`define SESS_LOSS_S   30
`define BLINK_HALF_MS 500
`define RESTART_US    10
`define MS_PER_S      1000
`define US_PER_S      1000000

`endif

// >>> src/safety_mode_pkg.sv
package safety_mode_pkg;

  // Operating states, one-hot
  typedef enum logic [5:0] {
    ST_INIT  = 6'h01,
    ST_PROG  = 6'h02,
    ST_DSTOP = 6'h04,
    ST_DRUN  = 6'h08,
    ST_RUN   = 6'h10,
    ST_FAULT = 6'h20
  } mode_t;

  // Indicator drive
  typedef struct packed {
    logic us_green;
    logic us_red;
    logic fs_green;
    logic fs_red;
    logic run_green;
    logic valid_yellow;
    logic debug_yellow;
  } led_t;

  // Mode side effects: levels then one-cycle pulses
  typedef struct packed {
    logic comm_run;
    logic prog_run;
    logic msg_en;
    logic force_en;
    logic var_init;
    logic zero_io;
    logic clr_force;
    logic nvm_erase;
    logic prog_start;
    logic restart;
  } act_t;

endpackage

// >>> src/safety_mode_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "safety_mode_defs.svh"

// How it works
// - Initializing: self-test, status and run flash green
// - Program: execution stopped, program indicator pattern
// - Run: validated programs, run green, valid yellow
// - Debug-stopped: standby, run dark, debug yellow
// - Debug-run: execute unvalidated, forcing allowed
// - Fatal error: fault state, status red only
// - Mode follows own inputs, never host CPU
// - Run download restarts unit, restart indicator pattern
// - Forced refresh only in debug modes
// - Debug entry needs online tool session
// - Debug session loss: program after 30 s
// - Only one online session, refuse second
// - Leaving program starts comm; run reinitialises
// - Debug-stop to debug-run: init, restart programs
// - Debug-run to debug-stop: init, stop, unforce
// - Run to program: stop, zero, erase
// - Debug to program: stop comm, zero I/O
// - Fault: stop everything, outputs to zero
// - Comm established: status and link flash green
// - Power-up: run if validated app, else program
// - Program to debug erases stored application
module safety_mode_sequencer
  import safety_mode_pkg::*;
#(
  parameter int          ADDR_W      = 8,
  parameter longint      CLK_HZ      = `CLK_HZ,
  parameter longint      LOSS_CYCLES = CLK_HZ * `SESS_LOSS_S,
  parameter longint      BLINK_CYC   = CLK_HZ * `BLINK_HALF_MS / `MS_PER_S,
  parameter int          RESTART_CYC = `CLK_HZ / `US_PER_S * `RESTART_US
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  init_done,
  input  wire logic                  nvm_app_valid,
  input  wire logic                  hw_fault,
  input  wire logic                  tool_link_up,
  input  wire logic                  comm_est,
  output var  safety_mode_pkg::led_t leds,
  output var  safety_mode_pkg::act_t act,
  output var  safety_mode_pkg::mode_t mode
);
  import safety_mode_pkg::*;

  localparam logic [31:0] LOSS_LAST  = 32'(LOSS_CYCLES - 1);
  localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
  localparam logic [15:0] RST_LAST   = 16'(RESTART_CYC - 1);

  mode_t       state_reg;
  mode_t       state_next;
  logic        online_reg, app_reg, restart_reg, blink_reg;
  logic [15:0] rst_cnt_reg;
  logic [31:0] loss_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic [3:0]  evt_reg;
  logic [3:0]  evt_set;
  logic        wr_cmd, wr_evt, acc;
  logic [2:0]  req;
  logic        req_ok, is_dbg, timeout, restart_done;
  logic [31:0] rd_next;
  logic        err_next;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------

  // Access phase handshake and write strobes
  assign acc    = psel && penable && pready;
  assign wr_cmd = acc && pwrite && (paddr == `ADDR_CMD);
  assign wr_evt = acc && pwrite && (paddr == `ADDR_EVT);
  assign req    = pwdata[`CMD_MODE_MSB:`CMD_MODE_LSB];

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr)
      `ADDR_CMD:  rd_next = 32'h0000_0000;
      `ADDR_STAT: rd_next = {21'h0, restart_reg, app_reg, online_reg, 2'h0, state_reg};
      `ADDR_LED:  rd_next = {25'h0, leds};
      `ADDR_EVT:  rd_next = {28'h0, evt_reg};
      default:    err_next = 1'b1;
    endcase
  end

  // Zero-wait answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err_next;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
      end
    end
  end

  // ------------------------------------------------------------
  // Session and timers
  // ------------------------------------------------------------

  assign is_dbg = (state_reg == ST_DSTOP) || (state_reg == ST_DRUN);

  // Single online session; link drop or cancel ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      online_reg <= 1'b0;
    end else if (!tool_link_up || state_reg == ST_FAULT) begin
      online_reg <= 1'b0;
    end else if (wr_cmd && pwdata[`CMD_SESS_OFF]) begin
      online_reg <= 1'b0;
    end else if (wr_cmd && pwdata[`CMD_SESS_ON]) begin
      online_reg <= 1'b1;
    end
  end

  // Session loss counter, cleared while online
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_cnt_reg <= 32'h0000_0000;
    end else if (online_reg || !is_dbg || timeout) begin
      loss_cnt_reg <= 32'h0000_0000;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
    end
  end
  assign timeout = is_dbg && !online_reg && (loss_cnt_reg == LOSS_LAST);

  // Shared blink divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  // Restart hold after a validated download in run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_reg <= 1'b0;
      rst_cnt_reg <= 16'h0000;
    end else if (state_reg != ST_RUN) begin
      restart_reg <= 1'b0;
      rst_cnt_reg <= 16'h0000;
    end else if (restart_reg) begin
      rst_cnt_reg <= rst_cnt_reg + 16'h0001;
    end else if (wr_cmd && pwdata[`CMD_DOWNLOAD]) begin
      restart_reg <= 1'b1;
    end
  end
  assign restart_done = restart_reg && (rst_cnt_reg == RST_LAST);

  // Stored application flag, loaded while initializing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_reg <= 1'b0;
    end else if (state_reg == ST_INIT) begin
      app_reg <= nvm_app_valid;
    end else if (act.nvm_erase) begin
      app_reg <= 1'b0;
    end else if (wr_cmd && pwdata[`CMD_DOWNLOAD] &&
                 (state_reg == ST_PROG || state_reg == ST_RUN)) begin
      app_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------

  // Legal requested changes from the current mode
  always_comb begin
    req_ok = 1'b0;
    case (state_reg)
      ST_PROG:  req_ok = (req == `REQ_DSTOP && online_reg) ||
                         (req == `REQ_RUN && app_reg);
      ST_DSTOP: req_ok = (req == `REQ_DRUN) || (req == `REQ_PROG);
      ST_DRUN:  req_ok = (req == `REQ_DSTOP) || (req == `REQ_PROG);
      ST_RUN:   req_ok = (req == `REQ_PROG) && !restart_reg;
      default:  req_ok = 1'b0;
    endcase
  end

  // Next mode from own inputs only, fault first
  always_comb begin
    state_next = state_reg;
    if (hw_fault) begin
      state_next = ST_FAULT;
    end else begin
      case (state_reg)
        ST_INIT: begin
          if (init_done) begin
            state_next = nvm_app_valid ? ST_RUN : ST_PROG;
          end
        end
        ST_PROG, ST_DSTOP, ST_DRUN, ST_RUN: begin
          if (timeout) begin
            state_next = ST_PROG;
          end else if (restart_done) begin
            state_next = ST_INIT;
          end else if (wr_cmd && req_ok) begin
            case (req)
              `REQ_PROG:  state_next = ST_PROG;
              `REQ_DSTOP: state_next = ST_DSTOP;
              `REQ_DRUN:  state_next = ST_DRUN;
              `REQ_RUN:   state_next = ST_RUN;
              default:    state_next = state_reg;
            endcase
          end
        end
        ST_FAULT: state_next = ST_FAULT;
        default:  state_next = ST_FAULT;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end
  assign mode = state_reg;

  // ------------------------------------------------------------
  // Events, set wins over write-one clear
  // ------------------------------------------------------------

  always_comb begin
    evt_set = 4'h0;
    evt_set[`EVT_FORCE_REJ] = wr_cmd && pwdata[`CMD_FORCE] &&
                              !(is_dbg && online_reg);
    evt_set[`EVT_SESS_REJ]  = wr_cmd && pwdata[`CMD_SESS_ON] && online_reg;
    evt_set[`EVT_MODE_REJ]  = wr_cmd && (req != 3'h0) && !req_ok;
    evt_set[`EVT_TIMEOUT]   = timeout;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= 4'h0;
    end else begin
      evt_reg <= (evt_reg & ~(wr_evt ? pwdata[3:0] : 4'h0)) | evt_set;
    end
  end

  // ------------------------------------------------------------
  // Side effects of each mode change
  // ------------------------------------------------------------

  // Levels follow the next mode, pulses mark each change except init to program or run; one process owns all of act
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= '0;
    end else begin
      act.comm_run   <= (state_next == ST_DSTOP) || (state_next == ST_DRUN) ||
                        (state_next == ST_RUN);
      act.prog_run   <= ((state_next == ST_RUN) && !restart_reg) ||
                        (state_next == ST_DRUN);
      act.msg_en     <= (state_next != ST_FAULT) && (state_next != ST_INIT);
      // Forcing is granted only in debug with a session, held while in debug, dropped on debug-run to debug-stop
      act.force_en   <= ((state_next == ST_DSTOP) || (state_next == ST_DRUN)) &&
                        !(state_reg == ST_DRUN && state_next == ST_DSTOP) &&
                        (act.force_en || (wr_cmd && pwdata[`CMD_FORCE] && is_dbg && online_reg));
      act.var_init   <= (state_reg == ST_PROG && state_next == ST_RUN) ||
                        (state_reg == ST_DSTOP && state_next == ST_DRUN) ||
                        (state_reg == ST_DRUN && state_next == ST_DSTOP) ||
                        (state_reg == ST_RUN && state_next == ST_PROG) ||
                        (state_reg == ST_DRUN && state_next == ST_PROG);
      act.zero_io    <= (state_reg != ST_PROG && state_next == ST_PROG &&
                         state_reg != ST_INIT) ||
                        (state_reg != ST_FAULT && state_next == ST_FAULT);
      act.clr_force  <= state_reg == ST_DRUN &&
                        (state_next == ST_DSTOP || state_next == ST_PROG);
      act.nvm_erase  <= (state_reg == ST_RUN && state_next == ST_PROG) ||
                        (state_reg == ST_PROG && state_next == ST_DSTOP);
      act.prog_start <= (state_reg == ST_PROG && state_next == ST_RUN) ||
                        (state_reg == ST_DSTOP && state_next == ST_DRUN);
      act.restart    <= restart_done;
    end
  end

  // ------------------------------------------------------------
  // Indicators
  // ------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds <= '0;
    end else begin
      leds <= '0;
      case (state_reg)
        ST_INIT: begin
          leds.us_green  <= blink_reg;
          leds.run_green <= blink_reg;
        end
        ST_PROG: begin
          leds.us_green     <= 1'b1;
          leds.fs_green     <= blink_reg;
          leds.valid_yellow <= app_reg;
        end
        ST_DSTOP, ST_DRUN, ST_RUN: begin
          if (comm_est || restart_reg) begin
            leds.us_green <= blink_reg;
            leds.fs_green <= blink_reg;
          end else begin
            leds.us_green <= 1'b1;
            leds.fs_green <= blink_reg;
            leds.fs_red   <= !blink_reg;
          end
          leds.run_green    <= state_reg != ST_DSTOP;
          leds.debug_yellow <= state_reg != ST_RUN;
          leds.valid_yellow <= app_reg && !restart_reg;
        end
        ST_FAULT: leds.us_red <= 1'b1;
        default:  leds.us_red <= 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_prog_to_run;
    state_reg == ST_PROG ##1 state_reg == ST_RUN;
  endsequence

  chk_fault_leds: assert property (
    state_reg == ST_FAULT |=> leds == 7'h20 && state_reg == ST_FAULT)
    else $error("fault indicators wrong");

  chk_fault_stop: assert property (
    state_reg != ST_FAULT && state_next == ST_FAULT |=>
      !act.comm_run && !act.prog_run && !act.msg_en && act.zero_io)
    else $error("fault did not stop outputs");

  chk_force_reject: assert property (
    wr_cmd && pwdata[`CMD_FORCE] && !is_dbg |=>
      evt_reg[`EVT_FORCE_REJ] && !act.force_en)
    else $error("force accepted outside debug");

  chk_debug_online: assert property (
    state_reg == ST_PROG && state_next == ST_DSTOP |-> online_reg
      ##1 act.nvm_erase && act.comm_run)
    else $error("debug entered without session");

  chk_loss_timeout: assert property (
    timeout && !hw_fault |=> state_reg == ST_PROG && act.zero_io)
    else $error("session loss did not return to program");

  chk_one_session: assert property (
    wr_cmd && pwdata[`CMD_SESS_ON] && online_reg |=> evt_reg[`EVT_SESS_REJ])
    else $error("second session not refused");

  chk_run_entry: assert property (
    s_prog_to_run |-> act.var_init && act.prog_start && act.comm_run)
    else $error("run entry actions missing");

  chk_run_leave: assert property (
    state_reg == ST_RUN && state_next == ST_PROG |=>
      act.nvm_erase && act.zero_io && !act.comm_run ##1 !app_reg)
    else $error("run to program actions missing");

  chk_init_leds: assert property (
    state_reg == ST_INIT |=> !leds.fs_green && !leds.valid_yellow &&
      !leds.debug_yellow && leds.us_green == leds.run_green)
    else $error("initializing indicators wrong");

endmodule
`default_nettype wire

// >>> tb/safety_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Tool session and safety I/O units
// ------------------------------------------
module safety_partner
  import safety_mode_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  online,
  input  wire safety_mode_pkg::act_t act,
  output var  logic                  tool_link_up,
  output var  logic                  comm_est
);
  logic [1:0] dly;

  // A single tool transport that follows the bench's session wish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tool_link_up <= 1'b0;
    else
      tool_link_up <= online;
  end

  // I/O units answer a started link after a short handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 2'h0;
      comm_est <= 1'b0;
    end else begin
      dly <= !act.comm_run ? 2'h0 : (dly == 2'h3 ? dly : dly + 2'h1);
      comm_est <= act.comm_run && dly == 2'h3;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_safety_mode_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "safety_mode_defs.svh"
// ------------------------------------------
// Bench for the mode sequencer
// ------------------------------------------
module test_safety_mode_sequencer;
  import safety_mode_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, err, clr;
  logic        init_done, nvm_app_valid, hw_fault;
  logic        tool_link_up, comm_est, online;
  led_t        leds;
  act_t        act, seen;
  mode_t       mode;
  int          fail_count, num_checks;

  safety_mode_sequencer #(.LOSS_CYCLES(200), .BLINK_CYC(4), .RESTART_CYC(5)) safety_mode_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init_done(init_done),
    .nvm_app_valid(nvm_app_valid), .hw_fault(hw_fault),
    .tool_link_up(tool_link_up), .comm_est(comm_est),
    .leds(leds), .act(act), .mode(mode));
  safety_partner safety_partner_i (
    .pclk(pclk), .presetn(presetn), .online(online), .act(act),
    .tool_link_up(tool_link_up), .comm_est(comm_est));

  // Clock and pulse catcher
  always #5 pclk = ~pclk;
  always @(posedge pclk) seen <= clr ? '0 : (seen | act);

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 0, 1);
      report_and_stop();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic go(input logic [2:0] q);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, `ADDR_CMD, {29'h0, q});
    cyc(3);
  endtask
  task automatic evt(input int b, input logic e);
    apb(1'b0, `ADDR_EVT, 32'h0);
    chk("event bit", r[b], e);
    apb(1'b1, `ADDR_EVT, 32'h0000_000F);
  endtask
  task automatic wait_mode(input mode_t m, input int n);
    int i;
    for (i = 0; i < n && mode !== m; i++) @(posedge pclk);
    if (mode !== m) begin
      chk("mode wait", mode, m);
      report_and_stop();
    end
  endtask
  task automatic flash(input string n, input logic fs);
    int t;
    logic p;
    t = 0;
    p = leds.us_green;
    repeat (16) begin
      @(posedge pclk);
      chk(n, leds.us_green, fs ? leds.fs_green : leds.run_green);
      if (leds.us_green !== p) t++;
      p = leds.us_green;
    end
    chk(n, t >= 3, 1);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_init();
    chk("reset mode", mode, ST_INIT);
    chk("reset act", act, 0);
    presetn <= 1'b1;
    cyc(2);
    flash("init flash", 1'b0);
    chk("init dark", {leds.us_red, leds.fs_green, leds.fs_red, leds.valid_yellow, leds.debug_yellow}, 0);
    init_done <= 1'b1;
    wait_mode(ST_PROG, 20);
  endtask
  task automatic t_prog();
    cyc(1);
    chk("prog leds", {leds.run_green, leds.debug_yellow, act.prog_run}, 0);
    apb(1'b1, `ADDR_CMD, 32'h0000_0040);
    evt(`EVT_FORCE_REJ, 1'b1);
    go(`REQ_DSTOP);
    chk("no session", mode, ST_PROG);
    evt(`EVT_MODE_REJ, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", r, 32'h0000_0000);
  endtask
  task automatic t_debug();
    online <= 1'b1;
    cyc(3);
    apb(1'b1, `ADDR_CMD, 32'h0000_0010);
    apb(1'b1, `ADDR_CMD, 32'h0000_0010);
    evt(`EVT_SESS_REJ, 1'b1);
    apb(1'b0, `ADDR_STAT, 32'h0);
    chk("online", r[8], 1'b1);
    go(`REQ_DSTOP);
    chk("dstop", mode, ST_DSTOP);
    chk("dstop fx", {seen.comm_run, seen.nvm_erase}, 2'b11);
    chk("dstop leds", {leds.run_green, leds.debug_yellow, act.prog_run}, 3'b010);
    apb(1'b1, `ADDR_CMD, 32'h0000_0040);
    evt(`EVT_FORCE_REJ, 1'b0);
    chk("force on", act.force_en, 1'b1);
    go(`REQ_DRUN);
    chk("drun fx", {seen.var_init, seen.prog_start, act.comm_run, act.prog_run}, 4'hF);
    chk("drun leds", {leds.run_green, leds.debug_yellow}, 2'b11);
    cyc(6);
    flash("link flash", 1'b1);
    go(`REQ_DSTOP);
    chk("stop fx", {seen.var_init, seen.clr_force, act.comm_run, act.prog_run}, 4'hE);
    go(`REQ_DRUN);
    go(`REQ_PROG);
    chk("to prog", mode, ST_PROG);
    chk("prog fx", {seen.zero_io, seen.var_init, seen.clr_force, act.comm_run}, 4'hE);
  endtask
  task automatic t_loss();
    go(`REQ_DSTOP);
    go(`REQ_DRUN);
    online <= 1'b0;
    cyc(100);
    online <= 1'b1;
    cyc(3);
    apb(1'b1, `ADDR_CMD, 32'h0000_0010);
    online <= 1'b0;
    cyc(150);
    chk("loss restart", mode, ST_DRUN);
    wait_mode(ST_PROG, 80);
    evt(`EVT_TIMEOUT, 1'b1);
  endtask
  task automatic t_run();
    nvm_app_valid <= 1'b1;
    apb(1'b1, `ADDR_CMD, 32'h0000_0100);
    go(`REQ_RUN);
    chk("run", mode, ST_RUN);
    chk("run fx", {seen.var_init, seen.prog_start, act.comm_run}, 3'h7);
    chk("run leds", {leds.run_green, leds.valid_yellow, leds.debug_yellow}, 3'b110);
    go(`REQ_DSTOP);
    evt(`EVT_MODE_REJ, 1'b1);
    go(3'h0);
    apb(1'b1, `ADDR_CMD, 32'h0000_0100);
    cyc(2);
    chk("restart leds", {leds.run_green, leds.valid_yellow, leds.fs_red}, 3'b100);
    wait_mode(ST_INIT, 20);
    wait_mode(ST_RUN, 20);
    chk("restart pulse", seen.restart, 1'b1);
    go(`REQ_PROG);
    chk("erase fx", {seen.zero_io, seen.var_init, seen.nvm_erase, act.comm_run, act.prog_run}, 5'h1C);
  endtask
  task automatic t_fault();
    apb(1'b1, `ADDR_CMD, 32'h0000_0100);
    go(`REQ_RUN);
    clr <= 1'b1;
    hw_fault <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    hw_fault <= 1'b0;
    cyc(3);
    chk("fault", mode, ST_FAULT);
    chk("fault leds", leds, 7'h20);
    chk("fault fx", {act.comm_run, act.prog_run, act.msg_en, seen.zero_io}, 4'h1);
    go(`REQ_PROG);
    chk("fault held", mode, ST_FAULT);
  endtask

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {init_done, nvm_app_valid, hw_fault, online, clr} = '0;
    fail_count = 0;
    num_checks = 0;
    cyc(3);
    t_init();
    t_prog();
    t_debug();
    t_loss();
    t_run();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire
